// *** dv/cfg_cap_regs_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module cfg_cap_regs_props
  import cfg_regs_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic rst_b, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [3:0] pstrb, // Strobes
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic slotPwrMsg, // Message pulse
  input wire slot_pwr_t slotPwrIn, // Payload
  input wire logic memCycle, // Access strobe
  input wire mem_req_t memReq, // Access request
  input wire logic memBusy // Busy
);
  logic [31:0] lastWr_ff;
  slot_pwr_t pwrExp_ff;
  wire rdHit = pready && !pwrite;
  wire wrCtl = pready && pwrite && paddr == OFS_MEM_CTRL;
  wire rdHdr = rdHit && paddr == OFS_CAP_HDR;
  wire rdDev = rdHit && paddr == OFS_DEV_CAP;

  // Shadows so request and power checks need no access to internals
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lastWr_ff <= '0;
      pwrExp_ff <= '0;
    end else begin
      if (wrCtl && pstrb == 4'hf) lastWr_ff <= pwdata;
      if (slotPwrMsg) pwrExp_ff <= slotPwrIn;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_capId; rdHdr |-> prdata[7:0] == CAP_ID_VAL; endproperty
  a_capId: assert property (p_capId) else $error("capability_identifier wrong");
  property p_nextPtr; rdHdr |-> prdata[15:8] == NEXT_PTR_VAL; endproperty
  a_nextPtr: assert property (p_nextPtr) else $error("next pointer wrong");
  property p_capVer; rdHdr |-> prdata[19:16] == CAP_VER_VAL; endproperty
  a_capVer: assert property (p_capVer) else $error("version wrong");
  property p_portType; rdHdr |-> prdata[23:20] == PORT_TYPE_VAL; endproperty
  a_portType: assert property (p_portType) else $error("port type wrong");
  property p_hdrZero; rdHdr |-> prdata[31:24] == 8'h00; endproperty
  a_hdrZero: assert property (p_hdrZero) else $error("header top not zero");
  property p_devFixed; rdDev |-> prdata[14:0] == 15'h0000; endproperty
  a_devFixed: assert property (p_devFixed) else $error("dev fields wrong");
  property p_devRsvd; rdDev |-> prdata[17:16] == 2'h0 && prdata[31:28] == 4'h0; endproperty
  a_devRsvd: assert property (p_devRsvd) else $error("reserved not zero");
  property p_slotPwr; rdDev |-> prdata[27:18] == pwrExp_ff; endproperty
  a_slotPwr: assert property (p_slotPwr) else $error("slot power wrong");
  // Idle judged one cycle back, so the commit edge's own update is ignored
  property p_launch;
    wrCtl && pwdata[START_BIT] && pstrb[0] && !$past(memBusy) |-> ##[1:4] $rose(memCycle);
  endproperty
  a_launch: assert property (p_launch) else $error("no cycle launched");
  property p_req;
    $rose(memCycle) && lastWr_ff[START_BIT] |->
      memReq == {lastWr_ff[4:3], lastWr_ff[15:5], lastWr_ff[31:16]};
  endproperty
  a_req: assert property (p_req) else $error("request fields wrong");
  property p_finish; $fell(memCycle) |-> ##[0:3] !memBusy; endproperty
  a_finish: assert property (p_finish) else $error("busy stuck");

  c_launch: cover property ($rose(memCycle));
  c_slverr: cover property (pready && pslverr);
  c_pwr: cover property (slotPwrMsg);
endmodule
`default_nettype wire

// *** dv/cfg_eeprom_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cfg_eeprom_model
  import cfg_regs_pkg::*;
(
  input wire logic clock, // Core clock
  input wire logic memCycle, // Access strobe
  input wire mem_req_t memReq // Access request
);
  logic [15:0] mem [0:2047];
  logic memCycleQ = 1'b0;
  int cycles = 0;

  // One access per strobe rise; a held strobe must not count twice
  always @(posedge clock) begin
    memCycleQ <= memCycle;
    if (memCycle && !memCycleQ) begin
      cycles <= cycles + 1;
      if (memReq.cmd == CMD_WRITE) mem[memReq.addr] <= memReq.wdata;
    end
  end
endmodule
`default_nettype wire

// *** dv/eeprom_ctrl_and_pcie_cap_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module eeprom_ctrl_and_pcie_cap_regs_tb;
  import cfg_regs_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic slotPwrMsg = 1'b0;
  slot_pwr_t slotPwrIn = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic memCycle;
  logic memBusy;
  mem_req_t memReq;
  logic [31:0] rd;
  logic err;
  int errorCnt = 0;
  int checks = 0;
  int cycleCnt = 0;

  initial begin
    forever #12.5 clock = ~clock;
  end

  // Short memory cycle keeps the busy window long enough to hit it
  cfg_cap_regs #(.CYCLE_LEN(4), .NUM_PRELOAD(1)) u_cfg_cap_regs (.clock(clock), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slotPwrMsg(slotPwrMsg), .slotPwrIn(slotPwrIn), .memCycle(memCycle), .memReq(memReq),
    .memBusy(memBusy));
  cfg_eeprom_model u_cfg_eeprom_model (.clock(clock), .memCycle(memCycle), .memReq(memReq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errorCnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One transfer; an edge always passes before the next setup
  task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] dat,
                     input logic [3:0] stb);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= dat;
    pstrb <= stb;
    @(posedge clock);
    penable <= 1'b1;
    // Waits as long as the slave asks; only the hang guard ends it
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp);
    apb(1'b0, adr, 32'h0, 4'h0);
    chk(rd, exp);
  endtask

  // Polls the control register until the given bit drops
  task automatic waitIdle(input int pos);
    int n;
    n = 0;
    do apb(1'b0, OFS_MEM_CTRL, 32'h0, 4'h0); while (rd[pos] !== 1'b0 && n++ < 30);
    chk(32'(rd[pos]), 32'h0);
  endtask

  task automatic tReset;
    rdChk(OFS_MEM_CTRL, 32'h0000_0000);
    rdChk(OFS_CAP_HDR, 32'h0011_0010);
    rdChk(OFS_DEV_CAP, 32'h0000_8000);
  endtask

  task automatic tReadOnly;
    apb(1'b1, OFS_CAP_HDR, 32'hffff_ffff, 4'hf);
    apb(1'b1, OFS_DEV_CAP, 32'hffff_ffff, 4'hf);
    rdChk(OFS_CAP_HDR, 32'h0011_0010);
    rdChk(OFS_DEV_CAP, 32'h0000_8000);
    rdChk(8'h40, 32'h0);
    chk(32'(err), 32'h1);
  endtask

  task automatic tFields;
    apb(1'b1, OFS_MEM_CTRL, 32'ha5c3_fff2, 4'hf);
    rdChk(OFS_MEM_CTRL, 32'ha5c3_fff0);
    apb(1'b1, OFS_MEM_CTRL, 32'h0, 4'h8);
    rdChk(OFS_MEM_CTRL, 32'h00c3_fff0);
  endtask

  // Second start lands while busy and must not launch
  task automatic tMemCycle;
    apb(1'b1, OFS_MEM_CTRL, {16'h1234, 11'h155, CMD_WRITE, 3'b001}, 4'hf);
    apb(1'b1, OFS_MEM_CTRL, {16'h5678, 11'h2aa, CMD_WRITE, 3'b001}, 4'hf);
    waitIdle(START_BIT);
    chk(32'(u_cfg_eeprom_model.cycles), 32'h1);
    chk({16'h0, u_cfg_eeprom_model.mem[11'h155]}, 32'h1234);
    rdChk(OFS_MEM_CTRL, {16'h5678, 11'h2aa, CMD_WRITE, 3'b000});
    apb(1'b1, OFS_MEM_CTRL, {16'h0, 11'h155, CMD_READ, 3'b001}, 4'hf);
    waitIdle(START_BIT);
    chk(32'(u_cfg_eeprom_model.cycles), 32'h2);
    chk({16'h0, u_cfg_eeprom_model.mem[11'h155]}, 32'h1234);
  endtask

  task automatic tPreload;
    apb(1'b1, OFS_MEM_CTRL, 32'h0000_0004, 4'hf);
    waitIdle(PRELOAD_BIT);
    chk(32'(u_cfg_eeprom_model.cycles), 32'h3);
    rdChk(OFS_DEV_CAP, 32'h0000_8000);
  endtask

  // Payload changes after the pulse must not be captured
  task automatic tSlotPwr;
    @(posedge clock);
    slotPwrIn <= {2'h2, 8'hc5};
    slotPwrMsg <= 1'b1;
    @(posedge clock);
    slotPwrMsg <= 1'b0;
    slotPwrIn <= {2'h1, 8'h3c};
    rdChk(OFS_DEV_CAP, 32'h0b14_8000);
  endtask

  // Reset in mid-run must drop stored fields and captured power
  task automatic tMidReset;
    apb(1'b1, OFS_MEM_CTRL, 32'hbeef_0010, 4'hf);
    rdChk(OFS_MEM_CTRL, 32'hbeef_0010);
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    rdChk(OFS_MEM_CTRL, 32'h0000_0000);
    rdChk(OFS_DEV_CAP, 32'h0000_8000);
  endtask

  task automatic wrapUp;
    $display("checks=%0d errors=%0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    tReset;
    tReadOnly;
    tFields;
    tMemCycle;
    tPreload;
    tSlotPwr;
    tMidReset;
    wrapUp;
  end

  // Hang guard, well above the roughly 120 cycles the run needs
  always @(posedge clock) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 3000) begin
      errorCnt++;
      wrapUp;
    end
  end
endmodule

bind cfg_cap_regs cfg_cap_regs_props u_cfg_cap_regs_props (.clock(clock), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .slotPwrMsg(slotPwrMsg), .slotPwrIn(slotPwrIn), .memCycle(memCycle), .memReq(memReq),
  .memBusy(memBusy));
`default_nettype wire

// *** rtl/apb_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module apb_decode
  import cfg_regs_pkg::*;
(
  input wire logic psel,                  // Slave select
  input wire logic penable,               // Access phase
  input wire logic pwrite,                // Write direction
  input wire logic [7:0] paddr,           // Byte address
  output logic wrCtrl,                    // Write to memory control
  output logic hitCtrl,                   // Control register addressed
  output logic hitCap,                    // Capability header addressed
  output logic hitDev,                    // Device capabilities addressed
  output logic unmapped                   // No register at address
);

  // Decode is purely combinational; the slave answers after one wait state
  assign hitCtrl = (paddr == OFS_MEM_CTRL);
  assign hitCap = (paddr == OFS_CAP_HDR);
  assign hitDev = (paddr == OFS_DEV_CAP);
  assign unmapped = !(hitCtrl || hitCap || hitDev);
  assign wrCtrl = psel && penable && pwrite && hitCtrl;

endmodule
`default_nettype wire

// *** rtl/cfg_cap_regs.sv ***
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module cfg_cap_regs
  import cfg_regs_pkg::*;
#(
  parameter int CYCLE_LEN = MEM_CYCLE_LEN,
  parameter int NUM_PRELOAD = PRELOAD_WORDS
) (
  input wire logic clock,                 // Core clock, 40 MHz
  input wire logic rst_b,                 // Async reset, active low
  input wire logic psel,                  // APB select
  input wire logic penable,               // APB enable
  input wire logic pwrite,                // APB direction
  input wire logic [7:0] paddr,           // APB byte address
  input wire logic [31:0] pwdata,         // APB write data
  input wire logic [3:0] pstrb,           // APB byte strobes
  output logic [31:0] prdata,             // APB read data
  output logic pready,                    // APB ready
  output logic pslverr,                   // APB error, unmapped
  input wire logic slotPwrMsg,            // Power limit message pulse
  input wire slot_pwr_t slotPwrIn,        // Message payload
  output logic memCycle,                  // Memory access strobe
  output mem_req_t memReq,                // Memory access request
  output logic memBusy                    // Sequencer busy
);

  // Sequencer counters are eight bits wide, so larger counts cannot be served
  localparam bit PARAM_OK = (CYCLE_LEN >= 1) && (CYCLE_LEN <= 255) &&
                            (NUM_PRELOAD >= 1) && (NUM_PRELOAD <= 255);
  if (!PARAM_OK) begin : g_badParam
    $error("cfg_cap_regs: bad parameter");
  end

  logic wrCtrl, hitCtrl, hitCap, hitDev, unmapped;
  logic seqBusy, seqDone, seqCycle, loadRoleErr, roleErrVal;
  mem_req_t seqReq;

  apb_decode u_dec (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .wrCtrl(wrCtrl),
    .hitCtrl(hitCtrl),
    .hitCap(hitCap),
    .hitDev(hitDev),
    .unmapped(unmapped)
  );

  // Control register state
  logic start_ff, nxt_start;
  logic preload_ff, nxt_preload;
  logic [1:0] cmd_ff, nxt_cmd;
  logic [10:0] addr_ff, nxt_addr;
  logic [15:0] wdata_ff, nxt_wdata;
  logic roleErr_ff, nxt_roleErr;
  slot_pwr_t slotPwr_ff, nxt_slotPwr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, pslverr_ff;
  logic launch_ff, preGo_ff;

  // Current control word; reserved bit 1 is never stored and reads zero
  wire [31:0] ctrlNow = {wdata_ff, addr_ff, cmd_ff, preload_ff, 1'b0, start_ff};
  wire [31:0] ctrlMerged;

  // Byte-lane merge of a control write, one lane per strobe
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign ctrlMerged[i*8 +: 8] = pstrb[i] ? pwdata[i*8 +: 8] : ctrlNow[i*8 +: 8];
  end

  // Fields as they stand once the write lands
  wire [1:0] wrCmd = ctrlMerged[CMD_LSB +: 2];
  wire [10:0] wrAddr = ctrlMerged[ADDR_LSB +: 11];
  wire [15:0] wrWdata = ctrlMerged[WDATA_LSB +: 16];
  wire wrStart = ctrlMerged[START_BIT];
  wire wrPreload = ctrlMerged[PRELOAD_BIT];

  // Write happens on the completing edge only (pready high then)
  wire ctrlWrite = wrCtrl && pready_ff;
  // Start or preload while the sequencer runs is refused; fields still land
  wire startReq = ctrlWrite && wrStart && !seqBusy;
  wire preReq = ctrlWrite && wrPreload && !seqBusy;

  // Start and preload stay set until the sequencer completes; busy drops in the
  // same cycle as the done pulse, so a new request there must beat the clear
  always_comb begin
    nxt_cmd = cmd_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_start = start_ff;
    nxt_preload = preload_ff;
    if (seqDone) begin
      nxt_start = 1'b0;
      nxt_preload = 1'b0;
    end
    if (ctrlWrite) begin
      nxt_cmd = wrCmd;
      nxt_addr = wrAddr;
      nxt_wdata = wrWdata;
      if (startReq) nxt_start = 1'b1;
      if (preReq) nxt_preload = 1'b1;
    end
  end

  // Preload may overwrite role-based error default
  assign nxt_roleErr = loadRoleErr ? roleErrVal : roleErr_ff;
  // Message capture; zero until the first message arrives
  assign nxt_slotPwr = slotPwrMsg ? slotPwrIn : slotPwr_ff;

  // Capability header, fixed fields; a write has no path to any flop here
  wire [7:0] capIdField = CAP_ID_VAL;
  wire [7:0] nextPtrField = NEXT_PTR_VAL;
  wire [3:0] capVerField = CAP_VER_VAL;
  wire [3:0] portTypeField = PORT_TYPE_VAL;
  wire slotImplField = 1'b0;
  wire [4:0] intMsgField = 5'h00;
  wire [1:0] hdrRsvdField = 2'h0;
  wire [31:0] capHdr = {hdrRsvdField, intMsgField, slotImplField, portTypeField,
                        capVerField, nextPtrField, capIdField};

  // Device capabilities; unimplemented features are tied low
  wire [2:0] payloadField = MAX_PAYLOAD_VAL;
  wire [1:0] phantomField = 2'h0;
  wire extTagField = 1'b0;
  wire [2:0] l0sLatField = L0S_LAT_RST;
  wire [2:0] l1LatField = L1_LAT_RST;
  wire [2:0] indicatorField = 3'h0;                    // No button or indicators
  wire roleErrField = roleErr_ff;
  wire [1:0] devRsvdLow = 2'h0;
  wire [7:0] pwrValField = slotPwr_ff.value;
  wire [1:0] pwrScaleField = slotPwr_ff.scale;
  wire [3:0] devRsvdHigh = 4'h0;
  wire [31:0] devCap = {devRsvdHigh, pwrScaleField, pwrValField, devRsvdLow,
                        roleErrField, indicatorField, l1LatField, l0sLatField,
                        extTagField, phantomField, payloadField};

  // Read selection; hits are exclusive, an unmapped read gives zero
  wire [31:0] ctrlRd = hitCtrl ? ctrlNow : 32'h0000_0000;
  wire [31:0] capRd = hitCap ? capHdr : 32'h0000_0000;
  wire [31:0] devRd = hitDev ? devCap : 32'h0000_0000;
  assign nxt_prdata = ctrlRd | capRd | devRd;

  // One wait state: ready rises in the second access cycle
  wire accessPhase = psel && penable && !pready_ff;
  wire rdAccess = accessPhase && !pwrite;
  wire errAccess = accessPhase && unmapped;

  // Command, address and data fields
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cmd_ff <= CMD_RSVD0;
      addr_ff <= 11'h000;
      wdata_ff <= 16'h0000;
    end else begin
      cmd_ff <= nxt_cmd;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
    end
  end

  // Start bit, polled by software for completion
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      start_ff <= 1'b0;
    end else begin
      start_ff <= nxt_start;
    end
  end

  // Preload bit, same life cycle as start
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      preload_ff <= 1'b0;
    end else begin
      preload_ff <= nxt_preload;
    end
  end

  // Role-based error bit, one out of reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      roleErr_ff <= ROLE_ERR_RST;
    end else begin
      roleErr_ff <= nxt_roleErr;
    end
  end

  // Captured slot power, zero until a message arrives
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      slotPwr_ff <= '0;
    end else begin
      slotPwr_ff <= nxt_slotPwr;
    end
  end

  // Ready pulse; low in the cycle after it so each access completes once
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= accessPhase;
    end
  end

  // Error flag rides with ready for unmapped addresses
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= errAccess;
    end
  end

  // Read data held to zero outside a read so stale words never leak
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata_ff <= 32'h0000_0000;
    end else begin
      prdata_ff <= rdAccess ? nxt_prdata : 32'h0000_0000;
    end
  end

  // Launch pulse registered so the sequencer sees stored command fields
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      launch_ff <= 1'b0;
    end else begin
      launch_ff <= startReq && !preReq;
    end
  end

  // Preload wins when both bits are written together
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      preGo_ff <= 1'b0;
    end else begin
      preGo_ff <= preReq;
    end
  end

  // Stored fields handed to the sequencer as one request
  mem_req_t seqReqIn;
  assign seqReqIn = '{cmd: cmd_ff, addr: addr_ff, wdata: wdata_ff};

  // Reserved command codes still run a cycle; software must not use them
  mem_access_seq #(
    .CYCLE_LEN(CYCLE_LEN),
    .NUM_PRELOAD(NUM_PRELOAD)
  ) u_seq (
    .clock(clock),
    .rst_b(rst_b),
    .launch(launch_ff),
    .preload(preGo_ff),
    .req(seqReqIn),
    .busy(seqBusy),
    .done(seqDone),
    .memCycle(seqCycle),
    .memReq(seqReq),
    .loadRoleErr(loadRoleErr),
    .roleErrVal(roleErrVal)
  );

  // Access strobe re-registered so it comes straight from a flop
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      memCycle <= 1'b0;
    end else begin
      memCycle <= seqCycle;
    end
  end

  // Request delayed with the strobe so both line up at the memory
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      memReq <= '0;
    end else begin
      memReq <= seqReq;
    end
  end

  // Launch term lets busy rise as the sequencer leaves idle, a cycle before the strobe
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      memBusy <= 1'b0;
    end else begin
      memBusy <= seqBusy || launch_ff || preGo_ff;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

endmodule
`default_nettype wire

// *** rtl/mem_access_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
module mem_access_seq
  import cfg_regs_pkg::*;
#(
  parameter int CYCLE_LEN = MEM_CYCLE_LEN,
  parameter int NUM_PRELOAD = PRELOAD_WORDS
) (
  input wire logic clock,                 // Core clock
  input wire logic rst_b,                 // Async reset, active low
  input wire logic launch,                // One-cycle single access request
  input wire logic preload,               // One-cycle preload request
  input wire mem_req_t req,               // Command, address, data
  output logic busy,                      // Cycle in progress
  output logic done,                      // One-cycle completion pulse
  output logic memCycle,                  // Access strobe toward memory
  output mem_req_t memReq,                // Access held toward memory
  output logic loadRoleErr,               // Preload word carries defaults
  output logic roleErrVal                 // Default loaded into role bit
);

  // Counters are eight bits wide, so larger counts cannot be served
  localparam bit PARAM_OK = (CYCLE_LEN >= 1) && (CYCLE_LEN <= 255) &&
                            (NUM_PRELOAD >= 1) && (NUM_PRELOAD <= 255);
  if (!PARAM_OK) begin : g_badParam
    $error("mem_access_seq: bad parameter");
  end

  typedef enum logic [1:0] {IDLE, SINGLE, PRELD} seq_state_t;

  seq_state_t state_ff, nxt_state;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [7:0] word_ff, nxt_word;
  mem_req_t req_ff, nxt_req;
  logic done_ff, nxt_done;
  logic load_ff, nxt_load;

  wire cycleEnd = (cnt_ff == 8'(CYCLE_LEN - 1));
  wire lastWord = (word_ff == 8'(NUM_PRELOAD - 1));

  // Single and preload cycles share one timer; preload walks low addresses
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_word = word_ff;
    nxt_req = req_ff;
    nxt_done = 1'b0;
    nxt_load = 1'b0;
    case (state_ff)
      IDLE: begin
        nxt_cnt = 8'h00;
        nxt_word = 8'h00;
        if (preload) begin
          nxt_state = PRELD;
          nxt_req = '{cmd: CMD_READ, addr: 11'h000, wdata: 16'h0000};
        end else if (launch) begin
          nxt_state = SINGLE;
          nxt_req = req;
        end
      end
      SINGLE: begin
        nxt_cnt = cnt_ff + 8'h01;
        if (cycleEnd) begin
          nxt_state = IDLE;
          nxt_done = 1'b1;
        end
      end
      PRELD: begin
        nxt_cnt = cnt_ff + 8'h01;
        if (cycleEnd) begin
          nxt_cnt = 8'h00;
          nxt_load = (word_ff == 8'h00);
          nxt_word = word_ff + 8'h01;
          nxt_req.addr = req_ff.addr + 11'h001;
          if (lastWord) begin
            nxt_state = IDLE;
            nxt_done = 1'b1;
          end
        end
      end
      default: nxt_state = IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= IDLE;
      cnt_ff <= 8'h00;
      word_ff <= 8'h00;
      req_ff <= '0;
      done_ff <= 1'b0;
      load_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      word_ff <= nxt_word;
      req_ff <= nxt_req;
      done_ff <= nxt_done;
      load_ff <= nxt_load;
    end
  end

  assign busy = (state_ff != IDLE);
  assign done = done_ff;
  assign memCycle = busy;
  assign memReq = req_ff;
  assign loadRoleErr = load_ff;
  // Read data path is outside; default image keeps the role bit set
  assign roleErrVal = ROLE_ERR_RST;

endmodule
`default_nettype wire

// *** shared/cfg_regs_pkg.sv ***
package cfg_regs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_MEM_CTRL = 8'hdc;
  localparam logic [7:0] OFS_CAP_HDR = 8'he0;
  localparam logic [7:0] OFS_DEV_CAP = 8'he4;

  // Memory control field positions
  localparam int START_BIT = 0;
  localparam int RSVD_BIT = 1;
  localparam int PRELOAD_BIT = 2;
  localparam int CMD_LSB = 3;
  localparam int ADDR_LSB = 5;
  localparam int WDATA_LSB = 16;

  // Command codes
  localparam logic [1:0] CMD_RSVD0 = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ = 2'h2;
  localparam logic [1:0] CMD_RSVD3 = 2'h3;

  // Fixed capability header contents
  localparam logic [7:0] CAP_ID_VAL = 8'h10;
  localparam logic [7:0] NEXT_PTR_VAL = 8'h00;
  localparam logic [3:0] CAP_VER_VAL = 4'h1;
  localparam logic [3:0] PORT_TYPE_VAL = 4'h1;

  // Device capabilities fields
  localparam logic [2:0] MAX_PAYLOAD_VAL = 3'h0;
  localparam logic [2:0] L0S_LAT_RST = 3'h0;
  localparam logic [2:0] L1_LAT_RST = 3'h0;
  localparam logic ROLE_ERR_RST = 1'b1;
  localparam int ROLE_ERR_BIT = 15;
  localparam int L0S_LSB = 6;
  localparam int L1_LSB = 9;
  localparam int PWR_VAL_LSB = 18;
  localparam int PWR_SCL_LSB = 26;

  // Memory cycle length in core clock cycles, and preload word count
  localparam int MEM_CYCLE_LEN = 16;
  localparam int PRELOAD_WORDS = 4;

  // Request handed to the memory sequencer
  typedef struct packed {
    logic [1:0] cmd;
    logic [10:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  // Captured slot power limit
  typedef struct packed {
    logic [1:0] scale;
    logic [7:0] value;
  } slot_pwr_t;

endpackage
